// ### src/pof_pkg.sv
// Shared constants and types of the profile output formatter
// Overview of operation
// - Software picks one of three output formats
// - Values carry calibration in selected distance unit
// - Uniform mode emits one 16-bit depth only
// - Negative depth results are reported invalid
// - 120 mm model: max code 60000, multiplier 2
// - 40 mm model: max code 40000, multiplier 1
// - Uniform mode resamples to more than 1024 points
// - Extra uniform points interpolate neighbouring real points
// - Invalid neighbour makes interpolated points invalid
// - XZ word is 16-bit X plus 16-bit depth
// - XZ mode emits one word per raw point
// - 64-bit item adds reflectance and width fields
// - Reflectance is raw peak intensity, unscaled
// - Fourth field carries peak width, multipurpose slot
// - Origin is lower left corner of range map
package pof_pkg;

  // Register word addresses
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_INV_CODE  = 4'h1;
  localparam logic [3:0]  REG_STATUS    = 4'h2;
  localparam logic [3:0]  REG_UNI_COUNT = 4'h3;
  localparam logic [3:0]  REG_MODEL     = 4'h4;

  // Register field positions and reset values
  localparam int          CTRL_FMT_LSB  = 0;
  localparam int          CTRL_FLAG_BIT = 2;
  localparam int          CTRL_UNIT_LSB = 3;
  localparam int          STAT_BUSY_BIT = 2;
  localparam int          STAT_CNT_LSB  = 16;
  localparam int          MODEL_MUL_LSB = 16;
  localparam logic        FLAG_EN_RST   = 1'b1;
  localparam logic [1:0]  UNIT_RST      = 2'h0;
  localparam logic [15:0] INV_CODE_RST  = 16'hffff;

  // Profile geometry
  localparam int          RAW_POINTS    = 1024;
  localparam int          UNI_POINTS    = 1280;
  localparam int          FRAC_BITS     = 8;

  // Model depth ranges
  localparam int          MR40_MAX_CODE  = 40000;
  localparam int          MR40_MULT      = 1;
  localparam int          MR120_MAX_CODE = 60000;
  localparam int          MR120_MULT     = 2;

  typedef enum logic [1:0] {
    FMT_UNIFORM = 2'h0,
    FMT_XZ      = 2'h1,
    FMT_XZRW    = 2'h2
  } pof_fmt_t;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_CAPT   = 6'h02,
    ST_FETCH0 = 6'h04,
    ST_FETCH1 = 6'h08,
    ST_EMIT   = 6'h10,
    ST_DRAIN  = 6'h20
  } pof_state_t;

endpackage

// ### src/pof_point_mem.sv
// Profile point store with registered read data
`timescale 1ns/100ps
module pof_point_mem #(
  parameter int DEPTH = 1024,
  parameter int WIDTH = 17
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     ce,
  input  wire logic                     rst_n,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Read port
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (ce && rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule

// ### src/pof_interp.sv
// Linear depth interpolation between two neighbouring points
`timescale 1ns/100ps
module pof_interp #(
  parameter int W  = 16,
  parameter int FW = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          rst_n,
  // Request
  input  wire logic          go,
  input  wire logic [W-1:0]  z0,
  input  wire logic          bad0,
  input  wire logic [W-1:0]  z1,
  input  wire logic          bad1,
  input  wire logic [FW-1:0] frac,
  // Result
  output logic               o_valid,
  output logic               o_bad,
  output logic [W-1:0]       o_z
);

  logic signed [W:0]      diff;
  logic signed [W+FW+1:0] prod;
  logic signed [W+FW+1:0] sum;

  always_comb begin
    diff = $signed({1'b0, z1}) - $signed({1'b0, z0});
    prod = diff * $signed({1'b0, frac});
    sum  = $signed({{(FW+2){1'b0}}, z0}) + (prod >>> FW);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      o_valid <= 1'b0;
      o_bad   <= 1'b0;
      o_z     <= '0;
    end else if (ce) begin
      o_valid <= go;
      if (go) begin
        o_bad <= bad0 | bad1;
        o_z   <= sum[W-1:0];
      end
    end
  end

  a_interp_bad: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    go && (bad0 || bad1) |=> o_valid && o_bad)
    else $error("interpolated point next to invalid point not flagged");

  a_interp_range: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    go |=> (o_z >= (($past(z0) < $past(z1)) ? $past(z0) : $past(z1)))
        && (o_z <= (($past(z0) < $past(z1)) ? $past(z1) : $past(z0))))
    else $error("interpolated depth outside its neighbours");

endmodule

// ### src/pof_formatter.sv
// Profile output formatter top: register port, capture, resampling, output words
`timescale 1ns/100ps
module pof_formatter #(
  parameter int MODEL_MR_MM = 120,
  parameter int RAW_N       = pof_pkg::RAW_POINTS,
  parameter int UNI_N       = pof_pkg::UNI_POINTS
) (
  // Clock, enable, reset
  input  wire logic               clk,
  input  wire logic               ce,
  input  wire logic               rst_n,
  // Register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  // Raw calibrated points
  input  wire logic               raw_valid,
  output logic                    raw_ready,
  input  wire logic [15:0]        raw_x,
  input  wire logic signed [17:0] raw_z,
  input  wire logic               raw_peak_ok,
  input  wire logic [15:0]        raw_refl,
  input  wire logic [15:0]        raw_width,
  // Output words
  output logic                    out_valid,
  output logic      [63:0]        out_data,
  output logic      [1:0]         out_format,
  output logic      [1:0]         out_unit,
  output logic                    out_first,
  output logic                    out_last
);

  localparam int IW = $clog2(RAW_N);
  localparam int UW = $clog2(UNI_N);
  localparam int PW = IW + pof_pkg::FRAC_BITS;
  localparam int FW = pof_pkg::FRAC_BITS;
  localparam int MAX_CODE_I = (MODEL_MR_MM == 40) ? pof_pkg::MR40_MAX_CODE : pof_pkg::MR120_MAX_CODE;
  localparam int MULT_I     = (MODEL_MR_MM == 40) ? pof_pkg::MR40_MULT : pof_pkg::MR120_MULT;
  localparam int Z_SHIFT    = $clog2(MULT_I);
  localparam logic [17:0]   MAX_CODE = 18'(MAX_CODE_I);
  localparam logic [PW-1:0] POS_STEP = PW'(((RAW_N - 1) << FW) / (UNI_N - 1));
  localparam logic [IW-1:0] RAW_LAST = IW'(RAW_N - 1);
  localparam logic [UW-1:0] UNI_LAST = UW'(UNI_N - 1);

  if (MODEL_MR_MM != 40 && MODEL_MR_MM != 120) begin : g_bad_model
    $error("unsupported measurement range model");
  end
  if (UNI_N <= RAW_N || RAW_N < 2 || (RAW_N & (RAW_N - 1)) != 0) begin : g_bad_points
    $error("uniform point count must exceed a power-of-two raw count");
  end

  // Reset release through two flops
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // Configuration
  pof_pkg::pof_fmt_t fmt_sel_q;
  pof_pkg::pof_fmt_t fmt_act_q;
  pof_pkg::pof_fmt_t fmt_cur;
  logic              flag_en_q;
  logic [1:0]        unit_sel_q;
  logic [1:0]        unit_act_q;
  logic [15:0]       inv_code_q;
  logic [15:0]       profile_cnt_q;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fmt_sel_q  <= pof_pkg::FMT_UNIFORM;
      flag_en_q  <= pof_pkg::FLAG_EN_RST;
      unit_sel_q <= pof_pkg::UNIT_RST;
      inv_code_q <= pof_pkg::INV_CODE_RST;
    end else if (ce && reg_wr) begin
      if (reg_addr == pof_pkg::REG_CTRL) begin
        // Reserved format code keeps the previous choice
        if (reg_wdata[pof_pkg::CTRL_FMT_LSB +: 2] != 2'h3) begin
          fmt_sel_q <= pof_pkg::pof_fmt_t'(reg_wdata[pof_pkg::CTRL_FMT_LSB +: 2]);
        end
        flag_en_q  <= reg_wdata[pof_pkg::CTRL_FLAG_BIT];
        unit_sel_q <= reg_wdata[pof_pkg::CTRL_UNIT_LSB +: 2];
      end
      if (reg_addr == pof_pkg::REG_INV_CODE) begin
        inv_code_q <= reg_wdata[15:0];
      end
    end
  end

  // Control state
  pof_pkg::pof_state_t state_q;
  pof_pkg::pof_state_t state_d;
  logic [IW-1:0]       raw_cnt_q;
  logic [UW-1:0]       uni_idx_q;
  logic [PW-1:0]       pos_q;
  logic                accept;

  assign accept  = raw_valid && raw_ready;
  // Format and unit are sampled only on the first point of a profile
  assign fmt_cur = (state_q == pof_pkg::ST_IDLE) ? fmt_sel_q : fmt_act_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      pof_pkg::ST_IDLE: begin
        if (accept) begin
          state_d = pof_pkg::ST_CAPT;
        end
      end
      pof_pkg::ST_CAPT: begin
        if (accept && raw_cnt_q == RAW_LAST) begin
          state_d = (fmt_act_q == pof_pkg::FMT_UNIFORM) ? pof_pkg::ST_FETCH0 : pof_pkg::ST_IDLE;
        end
      end
      pof_pkg::ST_FETCH0: begin
        state_d = pof_pkg::ST_FETCH1;
      end
      pof_pkg::ST_FETCH1: begin
        state_d = pof_pkg::ST_EMIT;
      end
      pof_pkg::ST_EMIT: begin
        state_d = (uni_idx_q == UNI_LAST) ? pof_pkg::ST_DRAIN : pof_pkg::ST_FETCH0;
      end
      pof_pkg::ST_DRAIN: begin
        state_d = pof_pkg::ST_IDLE;
      end
      default: begin
        state_d = pof_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q   <= pof_pkg::ST_IDLE;
      raw_ready <= 1'b0;
    end else if (ce) begin
      state_q   <= state_d;
      // Source stalls while a uniform profile is being resampled
      raw_ready <= (state_d == pof_pkg::ST_IDLE) || (state_d == pof_pkg::ST_CAPT);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fmt_act_q  <= pof_pkg::FMT_UNIFORM;
      unit_act_q <= pof_pkg::UNIT_RST;
      raw_cnt_q  <= '0;
    end else if (ce && accept) begin
      raw_cnt_q <= raw_cnt_q + 1'b1;
      if (state_q == pof_pkg::ST_IDLE) begin
        fmt_act_q  <= fmt_sel_q;
        unit_act_q <= unit_sel_q;
      end
    end
  end

  // Depth conversion of the incoming point
  logic signed [17:0] z_scaled;
  logic               z_neg;
  logic               z_bad;
  logic [15:0]        z_code;
  logic [15:0]        depth_field;

  always_comb begin
    z_scaled    = raw_z >>> Z_SHIFT;
    z_neg       = raw_z[17];
    z_bad       = z_neg || !raw_peak_ok || ($unsigned(z_scaled) > MAX_CODE);
    z_code      = z_scaled[15:0];
    depth_field = z_bad ? (flag_en_q ? inv_code_q : 16'h0000) : z_code;
  end

  // Uniform resampling walk
  logic [IW-1:0] pos_idx;
  logic [IW-1:0] pos_idx_nx;
  logic [IW-1:0] rd_addr;
  logic          rd_en;
  logic [16:0]   rd_data;
  logic [16:0]   near_q;
  logic          emit_last_q;
  logic          emit_first_q;
  logic          wr_en;

  assign pos_idx    = pos_q[PW-1:FW];
  assign pos_idx_nx = (pos_idx == RAW_LAST) ? pos_idx : pos_idx + 1'b1;
  assign rd_en      = (state_q == pof_pkg::ST_FETCH0) || (state_q == pof_pkg::ST_FETCH1);
  assign rd_addr    = (state_q == pof_pkg::ST_FETCH0) ? pos_idx : pos_idx_nx;
  assign wr_en      = accept && (fmt_cur == pof_pkg::FMT_UNIFORM);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pos_q        <= '0;
      uni_idx_q    <= '0;
      near_q       <= '0;
      emit_last_q  <= 1'b0;
      emit_first_q <= 1'b0;
    end else if (ce) begin
      if (state_q == pof_pkg::ST_FETCH1) begin
        near_q <= rd_data;
      end
      if (state_q == pof_pkg::ST_EMIT) begin
        emit_last_q  <= (uni_idx_q == UNI_LAST);
        emit_first_q <= (uni_idx_q == '0);
        pos_q        <= (uni_idx_q == UNI_LAST) ? '0 : pos_q + POS_STEP;
        uni_idx_q    <= (uni_idx_q == UNI_LAST) ? '0 : uni_idx_q + 1'b1;
      end
    end
  end

  pof_point_mem #(
    .DEPTH (RAW_N),
    .WIDTH (17)
  ) u_mem (
    .clk     (clk),
    .ce      (ce),
    .rst_n   (rst_sync_n),
    .wr_en   (wr_en),
    .wr_addr (raw_cnt_q),
    .wr_data ({z_bad, z_code}),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  logic        ip_valid;
  logic        ip_bad;
  logic [15:0] ip_z;

  pof_interp #(
    .W  (16),
    .FW (FW)
  ) u_interp (
    .clk     (clk),
    .ce      (ce),
    .rst_n   (rst_sync_n),
    .go      (state_q == pof_pkg::ST_EMIT),
    .z0      (near_q[15:0]),
    .bad0    (near_q[16]),
    .z1      (rd_data[15:0]),
    .bad1    (rd_data[16]),
    .frac    (pos_q[FW-1:0]),
    .o_valid (ip_valid),
    .o_bad   (ip_bad),
    .o_z     (ip_z)
  );

  // Output word assembly
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_valid  <= 1'b0;
      out_data   <= '0;
      out_format <= pof_pkg::FMT_UNIFORM;
      out_unit   <= pof_pkg::UNIT_RST;
      out_first  <= 1'b0;
      out_last   <= 1'b0;
    end else if (ce) begin
      out_valid <= 1'b0;
      out_first <= 1'b0;
      out_last  <= 1'b0;
      if (ip_valid) begin
        out_valid  <= 1'b1;
        out_data   <= {48'h0, ip_bad ? (flag_en_q ? inv_code_q : 16'h0000) : ip_z};
        out_format <= fmt_act_q;
        out_unit   <= unit_act_q;
        out_first  <= emit_first_q;
        out_last   <= emit_last_q;
      end else if (accept && fmt_cur != pof_pkg::FMT_UNIFORM) begin
        out_valid  <= 1'b1;
        out_format <= fmt_cur;
        out_unit   <= (state_q == pof_pkg::ST_IDLE) ? unit_sel_q : unit_act_q;
        out_first  <= (raw_cnt_q == '0);
        out_last   <= (raw_cnt_q == RAW_LAST);
        if (fmt_cur == pof_pkg::FMT_XZ) begin
          out_data <= {32'h0, depth_field, raw_x};
        end else begin
          out_data <= {raw_width, raw_refl, depth_field, raw_x};
        end
      end
    end
  end

  // Register read port
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      profile_cnt_q <= '0;
    end else if (ce && out_valid && out_last) begin
      profile_cnt_q <= profile_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          pof_pkg::REG_CTRL: begin
            reg_rdata[pof_pkg::CTRL_FMT_LSB +: 2]  <= fmt_sel_q;
            reg_rdata[pof_pkg::CTRL_FLAG_BIT]      <= flag_en_q;
            reg_rdata[pof_pkg::CTRL_UNIT_LSB +: 2] <= unit_sel_q;
          end
          pof_pkg::REG_INV_CODE: begin
            reg_rdata[15:0] <= inv_code_q;
          end
          pof_pkg::REG_STATUS: begin
            reg_rdata[1:0]                         <= fmt_act_q;
            reg_rdata[pof_pkg::STAT_BUSY_BIT]      <= (state_q != pof_pkg::ST_IDLE);
            reg_rdata[pof_pkg::STAT_CNT_LSB +: 16] <= profile_cnt_q;
          end
          pof_pkg::REG_UNI_COUNT: begin
            reg_rdata <= 32'(UNI_N);
          end
          pof_pkg::REG_MODEL: begin
            reg_rdata[15:0]                         <= MAX_CODE[15:0];
            reg_rdata[pof_pkg::MODEL_MUL_LSB +: 4]  <= 4'(MULT_I);
          end
          default: begin
            reg_rdata <= '0;
          end
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n || !ce);

  logic [UW:0] words_q;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      words_q <= '0;
    end else if (ce && out_valid) begin
      words_q <= out_last ? '0 : words_q + 1'b1;
    end
  end

  sequence s_fetch_pair;
    state_q == pof_pkg::ST_FETCH0 ##1 state_q == pof_pkg::ST_FETCH1 ##1 state_q == pof_pkg::ST_EMIT;
  endsequence

  sequence s_emit_out;
    ip_valid ##1 (out_valid && out_format == pof_pkg::FMT_UNIFORM);
  endsequence

  a_fmt_hold_profile: assert property (state_q != pof_pkg::ST_IDLE |=> $stable(fmt_act_q))
    else $error("format changed inside a profile");
  a_uniform_zonly: assert property (out_valid && out_format == pof_pkg::FMT_UNIFORM |-> out_data[63:16] == '0)
    else $error("uniform word carries more than depth");
  a_xz_word_width: assert property (out_valid && out_format == pof_pkg::FMT_XZ |-> out_data[63:32] == '0)
    else $error("XZ word wider than 32 bits");
  a_neg_depth_flag: assert property (accept && fmt_cur != pof_pkg::FMT_UNIFORM && raw_z < 0 && flag_en_q
    |=> out_valid && out_data[31:16] == $past(inv_code_q))
    else $error("negative depth not reported invalid");
  a_depth_scaled: assert property (accept && fmt_cur != pof_pkg::FMT_UNIFORM && !z_bad
    |=> out_data[31:16] == $past(raw_z[Z_SHIFT +: 16]))
    else $error("depth code not scaled by model multiplier");
  a_refl_width_pass: assert property (accept && fmt_cur == pof_pkg::FMT_XZRW
    |=> out_data[63:32] == {$past(raw_width), $past(raw_refl)})
    else $error("reflectance or width field wrong");
  a_xz_word_count: assert property (out_valid && out_last && out_format != pof_pkg::FMT_UNIFORM
    |-> words_q == (UW+1)'(RAW_N - 1))
    else $error("calibrated profile word count wrong");
  a_uni_word_count: assert property (out_valid && out_last && out_format == pof_pkg::FMT_UNIFORM
    |-> words_q == (UW+1)'(UNI_N - 1))
    else $error("uniform profile point count wrong");
  a_fetch_walk: assert property (state_q == pof_pkg::ST_FETCH0 && !$past(state_q == pof_pkg::ST_FETCH0)
    |-> s_fetch_pair ##1 s_emit_out)
    else $error("resampling step out of order");
  a_stall_resample: assert property (state_q == pof_pkg::ST_EMIT |-> !raw_ready)
    else $error("source not stalled during resampling");

endmodule

// ### tb/pof_host_model.sv
// Host-side receiver that gathers the output words of each profile
`timescale 1ns/100ps
module pof_host_model (
  // Clock
  input wire logic        clk,
  // Output words from the formatter
  input wire logic        out_valid,
  input wire logic [63:0] out_data,
  input wire logic [1:0]  out_format,
  input wire logic [1:0]  out_unit,
  input wire logic        out_first,
  input wire logic        out_last
);
  logic [63:0] dq[$];
  logic [5:0]  tq[$];

  // Host never stalls, so every valid pulse is taken unchanged as one word with its tags
  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      dq.push_back(out_data);
      tq.push_back({out_format, out_unit, out_first, out_last});
    end
  end
endmodule

// ### tb/pof_formatter_test.sv
// Self-checking bench of the profile output formatter
`timescale 1ns/100ps
module pof_formatter_test;
  localparam int RN = 16;
  localparam int UN = 20;
  logic               clk, ce, rst_n, reg_wr, reg_rd;
  logic [3:0]         reg_addr;
  logic [31:0]        reg_wdata, reg_rdata, rd;
  logic               raw_valid, raw_ready, raw_peak_ok;
  logic [15:0]        raw_x, raw_refl, raw_width;
  logic signed [17:0] raw_z;
  logic               out_valid, out_first, out_last;
  logic [63:0]        out_data;
  logic [1:0]         out_format, out_unit;
  logic [15:0]        px[RN], pr[RN], pw[RN];
  logic signed [17:0] pz[RN];
  logic               pk[RN];
  logic [31:0]        seed;
  int                 failures, compares;

  pof_formatter #(.MODEL_MR_MM(120), .RAW_N(RN), .UNI_N(UN)) u_pof_formatter (
    .clk(clk), .ce(ce), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_valid(raw_valid),
    .raw_ready(raw_ready), .raw_x(raw_x), .raw_z(raw_z), .raw_peak_ok(raw_peak_ok),
    .raw_refl(raw_refl), .raw_width(raw_width), .out_valid(out_valid), .out_data(out_data),
    .out_format(out_format), .out_unit(out_unit), .out_first(out_first), .out_last(out_last));

  pof_host_model u_pof_host_model (
    .clk(clk), .out_valid(out_valid), .out_data(out_data), .out_format(out_format),
    .out_unit(out_unit), .out_first(out_first), .out_last(out_last));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Model with multiplier 2 drops one bit of the raw micrometre value
  function automatic logic [15:0] exp_z(input logic signed [17:0] z, input logic ok,
                                        input logic fl, input logic [15:0] code);
    logic signed [17:0] c;
    c = z >>> (pof_pkg::MR120_MULT / 2);
    if (z < 0 || !ok || c > pof_pkg::MR120_MAX_CODE) begin
      return fl ? code : 16'h0000;
    end
    return c[15:0];
  endfunction

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask

  task automatic fill;
    for (int k = 0; k < RN; k++) begin
      seed = xs(seed);
      px[k] = seed[15:0];
      pr[k] = seed[31:16];
      seed = xs(seed);
      pz[k] = seed[17:0];
      pk[k] = seed[20:18] != 3'h0;
      pw[k] = seed[31:16];
    end
    // Edge cases: below zero, top code, one past top, lost peak
    pz[0] = -18'sd1;
    pz[1] = 18'sd120001;
    pz[2] = 18'sd120002;
    pk[3] = 1'b0;
    pz[4] = 18'sd0;
  endtask

  task automatic run_profile(input logic [1:0] fmt, input logic fl, input logic [15:0] code,
                             input logic [1:0] un, input logic mid);
    int          n;
    int          cnt;
    int          p;
    int          ix;
    int          z0;
    int          z1;
    logic        bad;
    logic [15:0] d;
    logic [63:0] e;
    u_pof_host_model.dq.delete();
    u_pof_host_model.tq.delete();
    cnt = (fmt == pof_pkg::FMT_UNIFORM) ? UN : RN;
    for (int k = 0; k < RN; k++) begin
      raw_valid   <= 1'b1;
      raw_x       <= px[k];
      raw_z       <= pz[k];
      raw_peak_ok <= pk[k];
      raw_refl    <= pr[k];
      raw_width   <= pw[k];
      if (mid && k == 5) begin
        reg_wr <= 1'b0;
      end
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (raw_ready !== 1'b1 && n < 500);
      if (n >= 500) begin
        failures++;
        close_out();
      end
      @(posedge clk);
      // Switch format in mid profile; must wait for the next profile
      if (mid && k == 3) begin
        reg_addr  <= pof_pkg::REG_CTRL;
        reg_wdata <= {27'h0, 2'h0, 1'b1, pof_pkg::FMT_XZ};
        reg_wr    <= 1'b1;
      end
    end
    raw_valid <= 1'b0;
    n = 0;
    while (u_pof_host_model.dq.size() < cnt && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      failures++;
      close_out();
    end
    repeat (4) @(posedge clk);
    check("word count", 64'(u_pof_host_model.dq.size()), 64'(cnt));
    for (int k = 0; k < cnt && k < u_pof_host_model.dq.size(); k++) begin
      if (fmt == pof_pkg::FMT_UNIFORM) begin
        p   = k * (((RN - 1) * 256) / (UN - 1));
        ix  = p >> pof_pkg::FRAC_BITS;
        z0  = exp_z(pz[ix], 1'b1, fl, code);
        z1  = exp_z(pz[(ix + 1 < RN) ? ix + 1 : ix], 1'b1, fl, code);
        bad = !pk[ix] || (ix + 1 < RN && !pk[ix + 1]);
        d   = bad ? (fl ? code : 16'h0000) : 16'(z0 + (((z1 - z0) * (p % 256)) >>> pof_pkg::FRAC_BITS));
        e   = {48'h0, d};
      end else begin
        d = exp_z(pz[k], pk[k], fl, code);
        e = (fmt == pof_pkg::FMT_XZ) ? {32'h0, d, px[k]} : {pw[k], pr[k], d, px[k]};
      end
      check("word data", u_pof_host_model.dq[k], e);
      check("word tags", 64'(u_pof_host_model.tq[k]),
            64'({fmt, un, k == 0, k == cnt - 1}));
    end
  endtask

  initial begin
    failures    = 0;
    compares    = 0;
    seed        = 32'h45;
    ce          = 1'b1;
    rst_n       = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 4'h0;
    reg_wdata   = 32'h0;
    raw_valid   = 1'b0;
    raw_x       = 16'h0;
    raw_z       = 18'h0;
    raw_peak_ok = 1'b0;
    raw_refl    = 16'h0;
    raw_width   = 16'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    reg_read(pof_pkg::REG_CTRL, rd);
    check("ctrl reset", 64'(rd), 64'h4);
    reg_read(pof_pkg::REG_INV_CODE, rd);
    check("code reset", 64'(rd), 64'hffff);
    reg_read(pof_pkg::REG_UNI_COUNT, rd);
    check("uniform count", 64'(rd), 64'(UN));
    reg_write(pof_pkg::REG_MODEL, 32'h0);
    reg_read(pof_pkg::REG_MODEL, rd);
    check("model word", 64'(rd), 64'h0002_ea60);
    reg_read(4'hf, rd);
    check("unmapped", 64'(rd), 64'h0);
    // Format code 3 is refused while the other fields still land
    reg_write(pof_pkg::REG_CTRL, 32'h3);
    reg_read(pof_pkg::REG_CTRL, rd);
    check("ctrl refuse", 64'(rd), 64'h0);
    fill();
    reg_write(pof_pkg::REG_CTRL, {27'h0, 2'h1, 1'b1, pof_pkg::FMT_XZ});
    run_profile(pof_pkg::FMT_XZ, 1'b1, 16'hffff, 2'h1, 1'b0);
    fill();
    reg_write(pof_pkg::REG_CTRL, {27'h0, 2'h2, 1'b1, pof_pkg::FMT_XZRW});
    reg_write(pof_pkg::REG_INV_CODE, 32'h1234);
    run_profile(pof_pkg::FMT_XZRW, 1'b1, 16'h1234, 2'h2, 1'b1);
    fill();
    reg_write(pof_pkg::REG_CTRL, {27'h0, 2'h0, 1'b0, pof_pkg::FMT_XZ});
    run_profile(pof_pkg::FMT_XZ, 1'b0, 16'h1234, 2'h0, 1'b0);
    // Depth ramp so interpolated points differ from their neighbours
    for (int k = 0; k < RN; k++) begin
      pz[k] = 18'(2000 + 96 * k);
      pk[k] = 1'b1;
    end
    pk[5]  = 1'b0;
    pk[RN - 1] = 1'b0;
    reg_write(pof_pkg::REG_INV_CODE, 32'hffff);
    reg_write(pof_pkg::REG_CTRL, {27'h0, 2'h3, 1'b1, pof_pkg::FMT_UNIFORM});
    run_profile(pof_pkg::FMT_UNIFORM, 1'b1, 16'hffff, 2'h3, 1'b0);
    reg_read(pof_pkg::REG_STATUS, rd);
    check("status", 64'(rd), 64'h0004_0000);
    close_out();
  end
endmodule
